// [setpoint_menu_regs.svh]
// Constants for the setpoint menu and pulse output block
`ifndef SETPOINT_MENU_REGS_SVH
`define SETPOINT_MENU_REGS_SVH
// Sized so the ten-second product stays unsigned and does not wrap
`define CLK_HZ 32'h0EE6B280
`define INACT_TIMEOUT_S 32'h0000000A
`define INACT_TIMEOUT_CYC (`CLK_HZ * `INACT_TIMEOUT_S)
`define CODE_DIGITS 4
`define SP_DIGITS 8
`define PEND_W 16
`define PW_W 24
`define CURRENT_FORCE_UA 3500
`endif

// [setpoint_menu_pkg.sv]
// Types for the setpoint menu and pulse output block
`default_nettype none
package setpoint_menu_pkg;
    typedef enum logic [10:0] {
        ST_DISPLAY = 11'h001,
        ST_CODE_PROMPT = 11'h002,
        ST_CODE_ENTRY = 11'h004,
        ST_CODE_OK = 11'h008,
        ST_SP_PROMPT = 11'h010,
        ST_SP_EDIT = 11'h020,
        ST_PROG_CODE = 11'h040,
        ST_PROG_MENU = 11'h080,
        ST_CL_PROMPT = 11'h100,
        ST_CL_EDIT = 11'h200,
        ST_CL_FUNC = 11'h400
    } menu_state_t;
    typedef struct packed {
        logic adv;
        logic back;
        logic up;
        logic down;
    } keys_t;
    typedef struct packed {
        logic [1:0] div_sel;
        logic [23:0] width;
    } pulse_cfg_t;
endpackage : setpoint_menu_pkg
`default_nettype wire

// [setpoint_menu_and_outputs.sv]
// Front-panel menu, current-loop calibration and pulse output logic
// How it works
// RQ1: Advance plus Up together in display mode opens the setpoint menu.
// RQ2: Unprotected entry shows first setpoint prompt, rate or total form.
// RQ3: Protected entry shows code prompt; advance starts per-digit code entry.
// RQ4: Matching code then back press shows the first setpoint prompt.
// RQ5: Wrong code or ten idle seconds return to display mode.
// RQ6: Up or Down toggles between first and second setpoint prompts.
// RQ7: Advance edits setpoint; back returns to prompt, back again exits.
// RQ8: Setpoint request ignored unless direct access menu is enabled.
// RQ9: Sink closes for programmed width per least digit change.
// RQ10: Divider of 10, 100, 1000 or 10000 on digit changes.
// RQ11: Pulses unsynchronised, spaced so rate is at most half width.
// RQ12: Pending pulses are cleared by power loss reset.
// RQ13: Advance plus back enters programme mode, code asked if protected.
// RQ14: Current function advance shows low endpoint; advance edits from MSD.
// RQ15: Up or Down selects high endpoint; three backs return to display.
// RQ16: Endpoint values accepted in either order.
// RQ17: Rate calibration change forces constant 3.5mA until recalibrated.
// RQ18: All-zero access code disables setpoint code protection.
// RQ19: Pending counter counts divided events up and emitted pulses down.
// RQ20: Idle timer restarts on every press, counted in clock ticks.
`timescale 1ns/1ps
`default_nettype none
`include "setpoint_menu_regs.svh"
module setpoint_menu_and_outputs
    import setpoint_menu_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = `INACT_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Push-buttons, one-cycle press pulses
    input wire keys_t i_keys,
    // Configuration
    input wire logic i_direct_setpoint_access_enable,
    input wire logic [15:0] i_setpoint_code,
    input wire logic [15:0] i_prog_code,
    input wire logic i_alarm_one_is_rate,
    input wire logic i_cal_change,
    input wire logic i_prog_menu_at_calib,
    // Totaliser least digit change pulse
    input wire logic i_lsd_change,
    input wire pulse_cfg_t i_pulse_cfg,
    // Display state
    output logic [10:0] o_menu_state,
    output logic o_rate_alarm_one_prompt,
    output logic o_total_alarm_one_prompt,
    output logic o_second_setpoint_prompt,
    output logic o_high_endpoint,
    output logic [2:0] o_edit_digit,
    output logic [15:0] o_code_entered,
    // Analog stage and pulse output
    output logic o_current_forced,
    output logic o_pulse_sink
);
    menu_state_t state_ff;
    logic sel_second_ff;
    logic high_ep_ff;
    logic [2:0] digit_ff;
    logic [15:0] code_ff;
    logic [31:0] idle_ff;
    logic forced_ff;
    logic [13:0] div_ff;
    logic [`PEND_W-1:0] pend_ff;
    logic [`PW_W-1:0] pw_cnt_ff;
    logic phase_on_ff;
    logic busy_ff;
    logic [13:0] div_max;
    logic div_evt;
    logic emit_start;
    logic any_key;
    logic code_timeout;
    logic [3:0] cur_nib;

    assign any_key = i_keys.adv | i_keys.back | i_keys.up | i_keys.down;
    assign code_timeout = idle_ff >= TIMEOUT_CYC - 1;
    assign cur_nib = code_ff[digit_ff[1:0]*4 +: 4];

    // Idle timer, only runs while a code is being asked for
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || any_key) begin
            idle_ff <= 32'h00000000; // [RQ20]
        end else if (state_ff == ST_CODE_PROMPT || state_ff == ST_CODE_ENTRY
                     || state_ff == ST_PROG_CODE) begin
            idle_ff <= idle_ff + 32'h00000001;
        end else begin
            idle_ff <= 32'h00000000;
        end
    end

    // Menu state machine
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state_ff <= ST_DISPLAY;
        end else begin
            unique case (state_ff)
                ST_DISPLAY: begin
                    if (i_keys.adv && i_keys.up && i_direct_setpoint_access_enable) begin
                        // [RQ1] [RQ8] [RQ18] [RQ2]
                        state_ff <= (i_setpoint_code == 16'h0000) ? ST_SP_PROMPT
                                                                  : ST_CODE_PROMPT;
                    end else if (i_keys.adv && i_keys.back) begin
                        // [RQ13]
                        state_ff <= (i_prog_code == 16'h0000) ? ST_PROG_MENU
                                                              : ST_PROG_CODE;
                    end
                end
                ST_CODE_PROMPT: begin
                    if (code_timeout) state_ff <= ST_DISPLAY; // [RQ5]
                    else if (i_keys.adv) state_ff <= ST_CODE_ENTRY; // [RQ3]
                end
                ST_CODE_ENTRY: begin
                    if (code_timeout) begin
                        state_ff <= ST_DISPLAY; // [RQ5]
                    end else if (i_keys.adv && digit_ff == 3'h3) begin
                        // Wrong code leaves at once, right code waits for back
                        state_ff <= (code_ff == i_setpoint_code) ? ST_CODE_OK
                                                                 : ST_DISPLAY; // [RQ5]
                    end
                end
                ST_CODE_OK: begin
                    if (i_keys.back) state_ff <= ST_SP_PROMPT; // [RQ4]
                end
                ST_SP_PROMPT: begin
                    if (i_keys.adv) state_ff <= ST_SP_EDIT; // [RQ7]
                    else if (i_keys.back) state_ff <= ST_DISPLAY; // [RQ7]
                end
                ST_SP_EDIT: begin
                    if (i_keys.back) state_ff <= ST_SP_PROMPT; // [RQ7]
                end
                ST_PROG_CODE: begin
                    if (code_timeout) state_ff <= ST_DISPLAY;
                    else if (i_keys.adv && digit_ff == 3'h3) begin
                        state_ff <= (code_ff == i_prog_code) ? ST_PROG_MENU : ST_DISPLAY;
                    end
                end
                ST_PROG_MENU: begin
                    if (i_prog_menu_at_calib) state_ff <= ST_CL_FUNC;
                    else if (i_keys.back) state_ff <= ST_DISPLAY;
                end
                ST_CL_FUNC: begin
                    if (i_keys.adv) state_ff <= ST_CL_PROMPT; // [RQ14]
                    else if (i_keys.back) state_ff <= ST_DISPLAY; // [RQ15]
                end
                ST_CL_PROMPT: begin
                    if (i_keys.adv) state_ff <= ST_CL_EDIT; // [RQ14]
                    else if (i_keys.back) state_ff <= ST_CL_FUNC; // [RQ15]
                end
                ST_CL_EDIT: begin
                    if (i_keys.back) state_ff <= ST_CL_PROMPT;
                end
                default: state_ff <= ST_DISPLAY;
            endcase
        end
    end

    // Prompt selection toggles
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || state_ff == ST_DISPLAY) begin
            sel_second_ff <= 1'b0;
            high_ep_ff <= 1'b0;
        end else if (i_keys.up || i_keys.down) begin
            if (state_ff == ST_SP_PROMPT) sel_second_ff <= ~sel_second_ff; // [RQ6]
            if (state_ff == ST_CL_PROMPT) high_ep_ff <= ~high_ep_ff; // [RQ15]
        end
    end

    // Digit cursor and code entry, code typed least significant digit first
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || state_ff == ST_DISPLAY || state_ff == ST_SP_PROMPT
            || state_ff == ST_CL_PROMPT || state_ff == ST_CODE_PROMPT) begin
            digit_ff <= 3'h0;
            code_ff <= 16'h0000;
        end else if (state_ff == ST_CODE_ENTRY || state_ff == ST_PROG_CODE) begin
            if (i_keys.adv) digit_ff <= digit_ff + 3'h1; // [RQ3]
            else if (i_keys.up) code_ff[digit_ff[1:0]*4 +: 4] <=
                (cur_nib == 4'h9) ? 4'h0 : cur_nib + 4'h1;
            else if (i_keys.down) code_ff[digit_ff[1:0]*4 +: 4] <=
                (cur_nib == 4'h0) ? 4'h9 : cur_nib - 4'h1;
        end else if (state_ff == ST_SP_EDIT || state_ff == ST_CL_EDIT) begin
            // Endpoint values stored as entered, no ordering check [RQ16]
            if (i_keys.adv) digit_ff <= (digit_ff == 3'h7) ? 3'h0 : digit_ff + 3'h1; // [RQ14]
        end
    end

    // Forced output until the current loop is recalibrated
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            forced_ff <= 1'b0;
        end else if (i_cal_change) begin
            forced_ff <= 1'b1; // [RQ17]
        end else if (state_ff == ST_CL_EDIT && i_keys.back) begin
            forced_ff <= 1'b0;
        end
    end

    // Divider on digit change events
    always_comb begin
        unique case (i_pulse_cfg.div_sel)
            2'h0: div_max = 14'h0009;
            2'h1: div_max = 14'h0063;
            2'h2: div_max = 14'h03E7;
            2'h3: div_max = 14'h270F;
        endcase
    end
    assign div_evt = i_lsd_change && (div_ff >= div_max);

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            div_ff <= 14'h0000;
        end else if (i_lsd_change) begin
            div_ff <= div_evt ? 14'h0000 : div_ff + 14'h0001; // [RQ10]
        end
    end

    assign emit_start = !busy_ff && (pend_ff != '0);

    // Pending pulse counter, cleared by power-on reset [RQ12]
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            pend_ff <= '0; // [RQ12]
        end else if (div_evt && !emit_start && pend_ff != '1) begin
            pend_ff <= pend_ff + 1'b1; // [RQ19]
        end else if (!div_evt && emit_start) begin
            pend_ff <= pend_ff - 1'b1; // [RQ19]
        end
    end

    // Pulse timer: on for width, then off for width
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            busy_ff <= 1'b0;
            phase_on_ff <= 1'b0;
            pw_cnt_ff <= '0;
        end else if (emit_start) begin
            busy_ff <= 1'b1; // [RQ9]
            phase_on_ff <= 1'b1;
            pw_cnt_ff <= '0;
        end else if (busy_ff) begin
            if (pw_cnt_ff + 1'b1 >= i_pulse_cfg.width) begin
                pw_cnt_ff <= '0;
                phase_on_ff <= 1'b0; // [RQ11]
                if (!phase_on_ff) busy_ff <= 1'b0;
            end else begin
                pw_cnt_ff <= pw_cnt_ff + 1'b1;
            end
        end
    end

    // Registered outputs
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_menu_state <= 11'h001;
            o_rate_alarm_one_prompt <= 1'b0;
            o_total_alarm_one_prompt <= 1'b0;
            o_second_setpoint_prompt <= 1'b0;
            o_high_endpoint <= 1'b0;
            o_edit_digit <= 3'h0;
            o_code_entered <= 16'h0000;
            o_current_forced <= 1'b0;
            o_pulse_sink <= 1'b0;
        end else begin
            o_menu_state <= state_ff;
            o_rate_alarm_one_prompt <= state_ff == ST_SP_PROMPT && !sel_second_ff
                                       && i_alarm_one_is_rate; // [RQ2]
            o_total_alarm_one_prompt <= state_ff == ST_SP_PROMPT && !sel_second_ff
                                        && !i_alarm_one_is_rate;
            o_second_setpoint_prompt <= sel_second_ff;
            o_high_endpoint <= high_ep_ff;
            o_edit_digit <= digit_ff;
            o_code_entered <= code_ff;
            o_current_forced <= forced_ff;
            o_pulse_sink <= busy_ff && phase_on_ff;
        end
    end

    // Checks
    gated_entry_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        state_ff == ST_DISPLAY && i_keys.adv && i_keys.up && !i_keys.back
        && !i_direct_setpoint_access_enable |=> state_ff == ST_DISPLAY) // [RQ8]
        else $error("setpoint menu opened while disabled");
    open_entry_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        state_ff == ST_DISPLAY && i_keys.adv && i_keys.up
        && i_direct_setpoint_access_enable && i_setpoint_code == 16'h0000
        |=> state_ff == ST_SP_PROMPT) // [RQ18]
        else $error("unprotected entry missed prompt");
    code_prompt_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        state_ff == ST_DISPLAY && i_keys.adv && i_keys.up
        && i_direct_setpoint_access_enable && i_setpoint_code != 16'h0000
        |=> state_ff == ST_CODE_PROMPT) // [RQ3]
        else $error("code prompt missing");
    code_ok_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        state_ff == ST_CODE_OK && i_keys.back |=> state_ff == ST_SP_PROMPT) // [RQ4]
        else $error("back after code did not open prompt");
    timeout_exit_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        state_ff == ST_CODE_ENTRY && code_timeout |=> state_ff == ST_DISPLAY) // [RQ5]
        else $error("idle code entry did not time out");
    sp_toggle_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        state_ff == ST_SP_PROMPT && i_keys.up && !i_keys.adv && !i_keys.back
        |=> sel_second_ff != $past(sel_second_ff)) // [RQ6]
        else $error("setpoint prompt did not toggle");
    forced_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_cal_change |=> ##1 o_current_forced) // [RQ17]
        else $error("current not forced after calibration change");
    pulse_width_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        $rose(o_pulse_sink) && i_pulse_cfg.width == 24'h000002 && $stable(i_pulse_cfg)
        |=> o_pulse_sink ##1 !o_pulse_sink ##1 !o_pulse_sink) // [RQ11]
        else $error("pulse on or off time wrong");
    pend_down_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        emit_start && !div_evt |=> pend_ff == $past(pend_ff) - 1'b1) // [RQ19]
        else $error("pending count not decremented");
endmodule : setpoint_menu_and_outputs
`default_nettype wire

// [pulse_counter_model.sv]
// External pulse counter that watches the isolated pulse output
`timescale 1ns/1ps
`default_nettype none
module pulse_counter_model (
    // Clock
    input wire logic i_ref_clk,
    // Sink state and programmed width
    input wire logic i_sink,
    input wire logic [23:0] i_width,
    // Pulses seen and width or spacing faults
    output int o_count,
    output int o_bad
);
    // No reset: a real counter keeps its tally when the device loses power
    int count_q = 0;
    int bad_q = 0;
    int high_len = 0;
    int low_len = 0;
    logic prev = 1'b0;
    logic seen = 1'b0;
    assign o_count = count_q;
    assign o_bad = bad_q;
    // Measure each closed and open run of the sink in clock samples
    always @(posedge i_ref_clk) begin
        if (i_sink && !prev) begin
            count_q <= count_q + 1;
            if (seen && low_len < int'(i_width)) bad_q <= bad_q + 1;
            seen <= 1'b1;
            high_len <= 1;
        end else if (i_sink) begin
            high_len <= high_len + 1;
        end
        if (!i_sink && prev) begin
            if (high_len != int'(i_width)) bad_q <= bad_q + 1;
            low_len <= 1;
        end else if (!i_sink) begin
            low_len <= low_len + 1;
        end
        prev <= i_sink;
    end
endmodule : pulse_counter_model
`default_nettype wire

// [setpoint_menu_and_outputs_tb_top.sv]
// Self-checking bench for the setpoint menu and pulse output block
`timescale 1ns/1ps
`default_nettype none
module setpoint_menu_and_outputs_tb_top;
    import setpoint_menu_pkg::*;
    localparam int TO = 50;
    logic clk, rst, ena, is_rate, cal, at_cal, lsd;
    keys_t keys;
    logic [15:0] sp_code, pr_code;
    pulse_cfg_t cfg;
    logic [10:0] st;
    logic rp, tp, sp2, hi, forced, sink;
    logic [2:0] edg;
    logic [15:0] ent;
    logic [3:0] dg [4];
    int n_errors = 0;
    int checked = 0;
    int cnt, bad, div;
    int exp_cnt = 0;
    // Short idle timeout keeps the run brief
    setpoint_menu_and_outputs #(.TIMEOUT_CYC(TO)) i_setpoint_menu_and_outputs (
        .i_ref_clk(clk), .i_rst(rst), .i_keys(keys),
        .i_direct_setpoint_access_enable(ena), .i_setpoint_code(sp_code),
        .i_prog_code(pr_code), .i_alarm_one_is_rate(is_rate), .i_cal_change(cal),
        .i_prog_menu_at_calib(at_cal), .i_lsd_change(lsd), .i_pulse_cfg(cfg),
        .o_menu_state(st), .o_rate_alarm_one_prompt(rp), .o_total_alarm_one_prompt(tp),
        .o_second_setpoint_prompt(sp2), .o_high_endpoint(hi), .o_edit_digit(edg),
        .o_code_entered(ent), .o_current_forced(forced), .o_pulse_sink(sink));
    pulse_counter_model i_pulse_counter_model (.i_ref_clk(clk), .i_sink(sink),
        .i_width(cfg.width), .o_count(cnt), .o_bad(bad));
    // Verdict and end of run
    task automatic print_verdict;
        if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    // Compare helpers, one per kind of result
    task automatic chk_state(input menu_state_t e);
        checked++;
        if (st !== e) begin
            n_errors++;
            $display("BAD %0t state %h exp %h", $time, st, e);
        end
    endtask : chk_state
    task automatic chk_bit(input logic g, input logic e);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %0t bit %h exp %h", $time, g, e);
        end
    endtask : chk_bit
    task automatic chk_cnt(input int g, input int e);
        checked++;
        if (g != e) begin
            n_errors++;
            $display("BAD %0t count %h exp %h", $time, g, e);
        end
    endtask : chk_cnt
    task automatic chk_val(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %0t value %h exp %h", $time, g, e);
        end
    endtask : chk_val
    // One-cycle key press, then room for the two-cycle answer
    task automatic press(input keys_t k);
        keys = k;
        @(negedge clk);
        keys = '0;
        repeat (3) @(negedge clk);
    endtask : press
    // Bounded wait for the counter to reach a tally
    task automatic wait_cnt(input int e);
        int k;
        for (k = 0; k < 600 && cnt != e; k++) @(negedge clk);
        if (k == 600) begin
            n_errors++;
            $display("BAD %0t timeout %h exp %h", $time, cnt, e);
            print_verdict();
        end
    endtask : wait_cnt
    // Pulses on the digit-change input, one cycle high and one low
    task automatic digit_steps(input int n);
        for (int e = 0; e < n; e++) begin
            lsd = 1'b1;
            @(negedge clk);
            lsd = 1'b0;
            @(negedge clk);
        end
    endtask : digit_steps
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Main sequence
    initial begin
        void'($urandom(76));
        {rst, ena, is_rate, cal, at_cal, lsd} = 6'h20;
        {keys, sp_code, pr_code, cfg} = '0;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk_state(ST_DISPLAY);
        press(4'hA);
        chk_state(ST_DISPLAY);
        ena = 1'b1;
        // Unprotected entry, both alarm kinds
        for (int r = 0; r < 2; r++) begin
            is_rate = (r == 0);
            press(4'hA);
            chk_state(ST_SP_PROMPT);
            chk_bit(rp, is_rate);
            chk_bit(tp, !is_rate);
            press(4'h2);
            chk_bit(sp2, 1'b1);
            press(4'h1);
            chk_bit(sp2, 1'b0);
            press(4'h8);
            chk_state(ST_SP_EDIT);
            press(4'h4);
            chk_state(ST_SP_PROMPT);
            press(4'h4);
            chk_state(ST_DISPLAY);
        end
        // Protected entry, right code then a code off by one per digit
        for (int i = 0; i < 4; i++) dg[i] = 4'($urandom_range(9, (i == 3) ? 1 : 0));
        sp_code = {dg[3], dg[2], dg[1], dg[0]};
        for (int w = 0; w < 2; w++) begin
            press(4'hA);
            chk_state(ST_CODE_PROMPT);
            press(4'h8);
            chk_state(ST_CODE_ENTRY);
            for (int i = 0; i < 4; i++) begin
                repeat ((dg[i] + w) % 10) press(4'h2);
                press(4'h8);
            end
            chk_state(w ? ST_DISPLAY : ST_CODE_OK);
            if (w == 0) begin
                chk_val(ent, sp_code);
                press(4'h4);
                chk_state(ST_SP_PROMPT);
                press(4'h4);
            end
        end
        // Idle timeout restarted by a press
        press(4'hA);
        press(4'h8);
        repeat (40) @(negedge clk);
        press(4'h2);
        repeat (30) @(negedge clk);
        chk_state(ST_CODE_ENTRY);
        repeat (30) @(negedge clk);
        chk_state(ST_DISPLAY);
        // Protected programme entry, code 0001 typed in
        pr_code = 16'h0001;
        press(4'hC);
        chk_state(ST_PROG_CODE);
        press(4'h2);
        repeat (4) press(4'h8);
        chk_state(ST_PROG_MENU);
        press(4'h4);
        chk_state(ST_DISPLAY);
        pr_code = 16'h0000;
        // Rate calibration change, then current-loop endpoint menu
        cal = 1'b1;
        @(negedge clk);
        cal = 1'b0;
        repeat (3) @(negedge clk);
        chk_bit(forced, 1'b1);
        press(4'hC);
        chk_state(ST_PROG_MENU);
        at_cal = 1'b1;
        repeat (3) @(negedge clk);
        chk_state(ST_CL_FUNC);
        at_cal = 1'b0;
        press(4'h8);
        chk_state(ST_CL_PROMPT);
        chk_bit(hi, 1'b0);
        press(4'h2);
        chk_bit(hi, 1'b1);
        press(4'h8);
        chk_state(ST_CL_EDIT);
        chk_val({13'h0000, edg}, 16'h0000);
        press(4'h8);
        chk_val({13'h0000, edg}, 16'h0001);
        chk_bit(forced, 1'b1);
        press(4'h4);
        chk_state(ST_CL_PROMPT);
        chk_bit(forced, 1'b0);
        press(4'h4);
        press(4'h4);
        chk_state(ST_DISPLAY);
        // Every divider setting, with a random width after the first
        for (int s = 0; s < 4; s++) begin
            div = 10 ** (s + 1);
            cfg.div_sel = 2'(s);
            // First setting pinned to width 2 so the pulse shape check fires
            cfg.width = (s == 0) ? 24'h000002 : 24'($urandom_range(8, 1));
            digit_steps(2 * div);
            exp_cnt += 2;
            wait_cnt(exp_cnt);
            repeat (40) @(negedge clk);
            chk_cnt(cnt, exp_cnt);
        end
        chk_cnt(bad, 0);
        // Power loss drops pulses still pending
        cfg = '{div_sel: 2'h0, width: 24'hFF};
        digit_steps(50);
        wait_cnt(exp_cnt + 1);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (1500) @(negedge clk);
        chk_cnt(cnt, exp_cnt + 1);
        chk_state(ST_DISPLAY);
        print_verdict();
    end
endmodule : setpoint_menu_and_outputs_tb_top
`default_nettype wire
